/* File: rtl/fmc_pkg.sv */
// Package with opcodes, table contents, timing and carrier types of the flash command block.
package fmc_pkg;
  localparam logic [7:0] OPC_LOCK_ALL = 8'h7E;
  localparam logic [7:0] OPC_UNLOCK_ALL = 8'h98;
  localparam logic [7:0] OPC_TABLE_READ = 8'h5A;
  localparam logic [7:0] OPC_BUSY_EN_DEF = 8'h70;
  localparam logic [7:0] OPC_BUSY_DIS_DEF = 8'h80;
  localparam logic [7:0] OPC_NOP_DEF = 8'h00;
  localparam logic [7:0] OPC_RESET_ARM_DEF = 8'h66;
  localparam logic [7:0] OPC_RESET_DEF = 8'h99;
  localparam logic [2:0] ADDR_BYTES = 3'h3;
  localparam logic [2:0] DUMMY_BYTES = 3'h1;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [31:0] TBL_SIGNATURE = 32'h50444653;
  localparam logic [7:0] TBL_MINOR_REV = 8'h00;
  localparam logic [7:0] TBL_MAJOR_REV = 8'h01;
  localparam logic [7:0] TBL_HDR_COUNT = 8'h01;
  localparam logic [7:0] TBL_UNUSED = 8'hFF;
  localparam logic [7:0] TBL_STD_ID = 8'h00;
  localparam logic [7:0] TBL_STD_LEN = 8'h09;
  localparam logic [23:0] TBL_STD_PTR = 24'h000030;
  localparam logic [7:0] TBL_VND_LEN = 8'h04;
  localparam logic [23:0] TBL_VND_PTR = 24'h000060;
  // Arbitrary neutral vendor code; not tied to any maker.
  localparam logic [7:0] TBL_VENDOR_ID_DEF = 8'h5E;
  localparam int CLK_PERIOD_NS = 20;
  localparam int RECOVER_PGM_NS = 40000;
  localparam int RECOVER_OTHER_NS = 20000;
  localparam int RECOVER_PGM_CYC = (RECOVER_PGM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVER_OTHER_CYC = (RECOVER_OTHER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RCNT_W = 16;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic si;
  } fmc_spi_in_s;

  typedef struct packed {
    logic lock_all;
    logic unlock_all;
    logic write_permit_clear;
    logic soft_reset;
    logic abort_operation;
  } fmc_pulse_s;

  typedef enum logic [2:0] {
    PH_OPCODE = 3'b000,
    PH_ADDR = 3'b001,
    PH_DUMMY = 3'b010,
    PH_DATA = 3'b011,
    PH_EXTRA = 3'b100
  } fmc_phase_e;
endpackage : fmc_pkg

/* File: rtl/fmc_cmd.sv */
// Serial command decoder for whole-chip lock, busy output, reset and parameter table read.
`timescale 1ns/1ps
module fmc_cmd #(
  parameter logic [7:0] OPC_BUSY_EN = fmc_pkg::OPC_BUSY_EN_DEF,
  parameter logic [7:0] OPC_BUSY_DIS = fmc_pkg::OPC_BUSY_DIS_DEF,
  parameter logic [7:0] OPC_NOP = fmc_pkg::OPC_NOP_DEF,
  parameter logic [7:0] OPC_RESET_ARM = fmc_pkg::OPC_RESET_ARM_DEF,
  parameter logic [7:0] OPC_RESET = fmc_pkg::OPC_RESET_DEF,
  parameter logic [7:0] VENDOR_ID = fmc_pkg::TBL_VENDOR_ID_DEF,
  parameter logic [15:0] RECOVER_PGM_CYCLES = 16'(fmc_pkg::RECOVER_PGM_CYC),
  parameter logic [15:0] RECOVER_OTHER_CYCLES = 16'(fmc_pkg::RECOVER_OTHER_CYC)
) (
  input wire logic clk,
  input wire logic rst,
  input wire fmc_pkg::fmc_spi_in_s spi_in,
  input wire logic [2:0] upper_io_lines,
  input wire logic wp_n,
  input wire logic individual_protect_select,
  input wire logic write_permit_latch,
  input wire logic continuous_program_mode,
  input wire logic ready_busy_n,
  input wire logic program_active,
  input wire logic erase_active,
  output logic so,
  output logic so_oe,
  output fmc_pkg::fmc_pulse_s pulses,
  output logic busy_output_enabled,
  output logic reset_armed,
  output logic protect_all_blocks,
  output logic standby
);
  // Pins from the host arrive asynchronously and pass two flip-flops first.
  fmc_pkg::fmc_spi_in_s meta_q, meta_d;
  fmc_pkg::fmc_spi_in_s sync_q, sync_d;
  logic sclk_prev_q, sclk_prev_d;
  logic cs_prev_q, cs_prev_d;
  logic wp_meta_q, wp_meta_d;
  logic wp_sync_q, wp_sync_d;

  fmc_pkg::fmc_phase_e phase_q, phase_d;
  logic [2:0] bit_q, bit_d;
  logic [2:0] cnt_q, cnt_d;
  logic [7:0] shift_q, shift_d;
  logic [7:0] opcode_q, opcode_d;
  logic [23:0] addr_q, addr_d;
  logic [2:0] obit_q, obit_d;
  logic data_started_q, data_started_d;
  logic so_q, so_d;
  logic busy_en_q, busy_en_d;
  logic arm_q, arm_d;
  logic [15:0] recover_q, recover_d;
  logic last_pgm_q, last_pgm_d;
  fmc_pkg::fmc_pulse_s pulse_q, pulse_d;

  logic sclk_rise;
  logic sclk_fall;
  logic cs_rise;
  logic cs_fall;
  logic cs_active;
  logic [7:0] in_byte;
  logic [7:0] tx_byte;
  logic boundary_one_byte;
  logic unused_upper;

  // Returns one byte of the discoverable parameter header area; anything else reads FFh.
  function automatic logic [7:0] table_byte(input logic [23:0] a, input logic [7:0] vid);
    logic [7:0] b;
    b = fmc_pkg::TBL_UNUSED;
    unique case (a)
      24'h000000: b = fmc_pkg::TBL_SIGNATURE[7:0];
      24'h000001: b = fmc_pkg::TBL_SIGNATURE[15:8];
      24'h000002: b = fmc_pkg::TBL_SIGNATURE[23:16];
      24'h000003: b = fmc_pkg::TBL_SIGNATURE[31:24];
      24'h000004: b = fmc_pkg::TBL_MINOR_REV;
      24'h000005: b = fmc_pkg::TBL_MAJOR_REV;
      24'h000006: b = fmc_pkg::TBL_HDR_COUNT;
      24'h000008: b = fmc_pkg::TBL_STD_ID;
      24'h000009: b = fmc_pkg::TBL_MINOR_REV;
      24'h00000A: b = fmc_pkg::TBL_MAJOR_REV;
      24'h00000B: b = fmc_pkg::TBL_STD_LEN;
      24'h00000C: b = fmc_pkg::TBL_STD_PTR[7:0];
      24'h00000D: b = fmc_pkg::TBL_STD_PTR[15:8];
      24'h00000E: b = fmc_pkg::TBL_STD_PTR[23:16];
      24'h000010: b = vid;
      24'h000011: b = fmc_pkg::TBL_MINOR_REV;
      24'h000012: b = fmc_pkg::TBL_MAJOR_REV;
      24'h000013: b = fmc_pkg::TBL_VND_LEN;
      24'h000014: b = fmc_pkg::TBL_VND_PTR[7:0];
      24'h000015: b = fmc_pkg::TBL_VND_PTR[15:8];
      24'h000016: b = fmc_pkg::TBL_VND_PTR[23:16];
      default: b = fmc_pkg::TBL_UNUSED;
    endcase
    return b;
  endfunction : table_byte

  // Pin synchronisers and edge history.
  always_comb
  begin
    meta_d = spi_in;
    sync_d = meta_q;
    sclk_prev_d = sync_q.sclk;
    cs_prev_d = sync_q.cs_n;
    wp_meta_d = wp_n;
    wp_sync_d = wp_meta_q;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_q <= '{cs_n: 1'b1, sclk: 1'b0, si: 1'b0};
      sync_q <= '{cs_n: 1'b1, sclk: 1'b0, si: 1'b0};
      sclk_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
      wp_meta_q <= 1'b1;
      wp_sync_q <= 1'b1;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      sclk_prev_q <= sclk_prev_d;
      cs_prev_q <= cs_prev_d;
      wp_meta_q <= wp_meta_d;
      wp_sync_q <= wp_sync_d;
    end
  end

  assign cs_active = ~sync_q.cs_n;
  assign sclk_rise = cs_active & sync_q.sclk & ~sclk_prev_q;
  assign sclk_fall = cs_active & ~sync_q.sclk & sclk_prev_q;
  assign cs_rise = sync_q.cs_n & ~cs_prev_q;
  assign cs_fall = ~sync_q.cs_n & cs_prev_q;
  assign in_byte = {shift_q[6:0], sync_q.si};
  // A function result cannot be bit-selected directly, so the table byte is named first.
  assign tx_byte = table_byte(addr_q, VENDOR_ID);
  // The upper data lines carry nothing these commands use.
  assign unused_upper = ^upper_io_lines;
  // Exactly one whole byte seen means chip select rose on the boundary.
  assign boundary_one_byte = (cnt_q == 3'h1) && (bit_q == 3'h0) &&
    (phase_q == fmc_pkg::PH_EXTRA);

  // Serial framing, decode and command effects.
  always_comb
  begin
    phase_d = phase_q;
    bit_d = bit_q;
    cnt_d = cnt_q;
    shift_d = shift_q;
    opcode_d = opcode_q;
    addr_d = addr_q;
    obit_d = obit_q;
    data_started_d = data_started_q;
    so_d = so_q;
    busy_en_d = busy_en_q;
    arm_d = arm_q;
    recover_d = recover_q;
    last_pgm_d = last_pgm_q;
    pulse_d = '0;
    if (program_active)
    begin
      last_pgm_d = 1'b1;
    end
    else if (erase_active)
    begin
      last_pgm_d = 1'b0;
    end
    if (recover_q != 16'h0000)
    begin
      recover_d = recover_q - 16'h0001;
    end
    if (cs_fall)
    begin
      phase_d = fmc_pkg::PH_OPCODE;
      bit_d = 3'h0;
      cnt_d = 3'h0;
      obit_d = 3'h0;
      data_started_d = 1'b0;
    end
    else if (sclk_rise && phase_q != fmc_pkg::PH_DATA)
    begin
      shift_d = in_byte;
      bit_d = bit_q + 3'h1;
      if (bit_q == fmc_pkg::BIT_LAST)
      begin
        unique case (phase_q)
          fmc_pkg::PH_OPCODE:
          begin
            opcode_d = in_byte;
            cnt_d = 3'h1;
            phase_d = (in_byte == fmc_pkg::OPC_TABLE_READ) ?
              fmc_pkg::PH_ADDR : fmc_pkg::PH_EXTRA;
          end
          fmc_pkg::PH_ADDR:
          begin
            addr_d = {addr_q[15:0], in_byte};
            cnt_d = cnt_q + 3'h1;
            if (cnt_q == fmc_pkg::ADDR_BYTES)
            begin
              phase_d = fmc_pkg::PH_DUMMY;
              cnt_d = 3'h0;
            end
          end
          fmc_pkg::PH_DUMMY:
          begin
            cnt_d = cnt_q + 3'h1;
            if (cnt_q + 3'h1 == fmc_pkg::DUMMY_BYTES)
            begin
              phase_d = fmc_pkg::PH_DATA;
            end
          end
          default:
          begin
            // Extra bytes after a single-byte command spoil the boundary.
            cnt_d = (cnt_q == 3'h7) ? cnt_q : cnt_q + 3'h1;
          end
        endcase
      end
    end
    else if (sclk_fall && phase_q == fmc_pkg::PH_DATA)
    begin
      // Table bytes go out most significant bit first, address advancing per byte.
      so_d = tx_byte[fmc_pkg::BIT_LAST - obit_q];
      data_started_d = 1'b1;
      obit_d = obit_q + 3'h1;
      if (obit_q == fmc_pkg::BIT_LAST)
      begin
        addr_d = addr_q + 24'h000001;
      end
    end
    if (cs_rise)
    begin
      // A table read may stop anywhere in data out and still counts as a command.
      if (phase_q == fmc_pkg::PH_DATA || phase_q == fmc_pkg::PH_ADDR ||
          phase_q == fmc_pkg::PH_DUMMY)
      begin
        arm_d = 1'b0;
      end
      else if (boundary_one_byte)
      begin
        arm_d = 1'b0;
        unique case (opcode_q)
          fmc_pkg::OPC_LOCK_ALL,
          fmc_pkg::OPC_UNLOCK_ALL:
          begin
            // Without the mode or the write permit the command is dropped quietly.
            if (individual_protect_select && write_permit_latch)
            begin
              pulse_d.lock_all = (opcode_q == fmc_pkg::OPC_LOCK_ALL);
              pulse_d.unlock_all = (opcode_q == fmc_pkg::OPC_UNLOCK_ALL);
              pulse_d.write_permit_clear = 1'b1;
            end
          end
          OPC_BUSY_EN:
          begin
            busy_en_d = 1'b1;
          end
          OPC_BUSY_DIS:
          begin
            busy_en_d = 1'b0;
          end
          OPC_NOP:
          begin
            arm_d = 1'b0;
          end
          OPC_RESET_ARM:
          begin
            arm_d = 1'b1;
          end
          OPC_RESET:
          begin
            if (arm_q)
            begin
              pulse_d.soft_reset = 1'b1;
              pulse_d.abort_operation = program_active | erase_active;
              busy_en_d = 1'b0;
              recover_d = (last_pgm_q | program_active) ?
                RECOVER_PGM_CYCLES : RECOVER_OTHER_CYCLES;
            end
          end
          default:
          begin
            arm_d = 1'b0;
          end
        endcase
      end
      // Anything else that ends off the boundary is rejected and leaves state alone.
      phase_d = fmc_pkg::PH_OPCODE;
      bit_d = 3'h0;
      cnt_d = 3'h0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      phase_q <= fmc_pkg::PH_OPCODE;
      bit_q <= 3'h0;
      cnt_q <= 3'h0;
      shift_q <= 8'h00;
      opcode_q <= 8'h00;
      addr_q <= 24'h000000;
      obit_q <= 3'h0;
      data_started_q <= 1'b0;
      so_q <= 1'b0;
      busy_en_q <= 1'b0;
      arm_q <= 1'b0;
      recover_q <= 16'h0000;
      last_pgm_q <= 1'b0;
      pulse_q <= '0;
    end
    else
    begin
      phase_q <= phase_d;
      bit_q <= bit_d;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      opcode_q <= opcode_d;
      addr_q <= addr_d;
      obit_q <= obit_d;
      data_started_q <= data_started_d;
      so_q <= so_d;
      busy_en_q <= busy_en_d;
      arm_q <= arm_d;
      recover_q <= recover_d;
      last_pgm_q <= last_pgm_d;
      pulse_q <= pulse_d;
    end
  end

  // Ready/busy is steered straight to the pin so it tracks the array without a byte lag.
  always_comb
  begin
    so = so_q;
    so_oe = 1'b0;
    if (cs_active && phase_q == fmc_pkg::PH_DATA && data_started_q)
    begin
      so = so_q;
      so_oe = 1'b1;
    end
    else if (busy_en_q && continuous_program_mode && !unused_upper | busy_en_q
             && continuous_program_mode)
    begin
      so = ready_busy_n;
      so_oe = 1'b1;
    end
  end

  assign pulses = pulse_q;
  assign busy_output_enabled = busy_en_q;
  assign reset_armed = arm_q;
  assign protect_all_blocks = individual_protect_select & ~wp_sync_q;
  assign standby = (recover_q == 16'h0000);
endmodule : fmc_cmd

/* File: tb/fmc_cmd_sva.sv */
// Port checker for the flash command decoder.
`timescale 1ns/1ps
module fmc_cmd_sva #(
  parameter logic [15:0] RECOVER_PGM_CYCLES = 16'h0014
) (
  input wire logic clk,
  input wire logic rst,
  input wire fmc_pkg::fmc_spi_in_s spi_in,
  input wire logic wp_n,
  input wire logic individual_protect_select,
  input wire logic write_permit_latch,
  input wire logic continuous_program_mode,
  input wire logic ready_busy_n,
  input wire logic so,
  input wire logic so_oe,
  input wire fmc_pkg::fmc_pulse_s pulses,
  input wire logic busy_output_enabled,
  input wire logic reset_armed,
  input wire logic protect_all_blocks,
  input wire logic standby
);
  logic [15:0] low_q;
  logic [15:0] low_d;
  always_comb low_d = standby ? 16'h0000 : low_q + 16'h0001;
  always_ff @(posedge clk) low_q <= rst ? 16'h0000 : low_d;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_LOCK_GATED:
    assert property ((pulses.lock_all || pulses.unlock_all) |->
      individual_protect_select && write_permit_latch) else $error("lock outside mode");
  AST_LOCK_PULSE:
    assert property (pulses.lock_all |-> pulses.write_permit_clear ##1 !pulses.lock_all)
    else $error("lock pulse malformed");
  AST_AFTER_FRAME:
    assert property ((pulses.lock_all || pulses.soft_reset) |-> spi_in.cs_n && $past(spi_in.cs_n, 2))
    else $error("command acted inside a frame");
  // Chip select must have been high a while, so a table byte cannot still be leaving.
  AST_BUSY_SO:
    assert property (busy_output_enabled && continuous_program_mode && spi_in.cs_n &&
      $past(spi_in.cs_n, 4) |-> so_oe && so == ready_busy_n) else $error("busy not on output");
  AST_SO_QUIET:
    assert property (!busy_output_enabled && spi_in.cs_n && $past(spi_in.cs_n, 4) |-> !so_oe)
    else $error("output driven while idle");
  AST_RESET_ARMED:
    assert property (pulses.soft_reset |-> $past(reset_armed)) else $error("reset without arm");
  AST_STANDBY_DROP:
    assert property ($rose(pulses.soft_reset) |-> ##[0:2] !standby) else $error("no recovery");
  AST_ABORT:
    assert property (pulses.abort_operation |-> pulses.soft_reset) else $error("abort alone");
  AST_RECOVER_BOUND:
    assert property (!standby |-> low_q <= RECOVER_PGM_CYCLES + 16'h0002)
    else $error("recovery too long");
  AST_PROTECT_MODE:
    assert property (protect_all_blocks |-> individual_protect_select) else $error("bad protect");
  AST_WP_LOW:
    assert property (individual_protect_select && !$past(wp_n, 2) && !$past(wp_n, 3) |->
      protect_all_blocks) else $error("pin low not protecting");
  COV_LOCK: cover property (pulses.lock_all);
  COV_RESET: cover property (pulses.soft_reset);
  COV_TABLE: cover property (so_oe && !spi_in.cs_n);
endmodule : fmc_cmd_sva

bind fmc_cmd fmc_cmd_sva #(.RECOVER_PGM_CYCLES(RECOVER_PGM_CYCLES)) u_sva (.clk, .rst, .spi_in,
  .wp_n, .individual_protect_select, .write_permit_latch, .continuous_program_mode,
  .ready_busy_n, .so, .so_oe, .pulses, .busy_output_enabled, .reset_armed, .protect_all_blocks,
  .standby);

/* File: tb/fmc_host.sv */
// Host model driving chip select, serial clock and serial input.
`timescale 1ns/1ps
module fmc_host (
  input wire logic clk,
  output fmc_pkg::fmc_spi_in_s spi_in,
  input wire logic so,
  input wire logic so_oe
);
  initial spi_in = 3'b100;
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // Data changes with the clock low; the reply is taken just before the next fall.
  task automatic shift(input logic [7:0] b, input logic [3:0] n, output logic [7:0] r);
    r = 8'h00;
    for (int i = 0; i < n; i++)
    begin
      spi_in.si <= b[7 - i];
      tick(4);
      spi_in.sclk <= 1'b1;
      tick(3);
      r = {r[6:0], (so_oe === 1'b1) ? so : 1'bx};
      tick(1);
      spi_in.sclk <= 1'b0;
    end
  endtask : shift
  task automatic open_frame();
    spi_in.cs_n <= 1'b0;
    tick(4);
  endtask : open_frame
  // Closing after a partial byte is how a short frame is made.
  task automatic close_frame();
    tick(4);
    spi_in.cs_n <= 1'b1;
    spi_in.si <= ~spi_in.si;
    tick(12);
  endtask : close_frame
endmodule : fmc_host

/* File: tb/test_flash_misc_cmd_and_param_table.sv */
// Self-checking bench of the flash command decoder.
`timescale 1ns/1ps
module test_flash_misc_cmd_and_param_table;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] upio = 3'h0;
  logic wp_n = 1'b1;
  logic ips = 1'b0;
  logic wpl = 1'b1;
  logic cpm = 1'b0;
  logic rbn = 1'b1;
  logic pga = 1'b0;
  logic era = 1'b0;
  logic so;
  logic so_oe;
  logic busy_en;
  logic armed;
  logic prot;
  logic standby;
  fmc_pkg::fmc_spi_in_s spi_in;
  fmc_pkg::fmc_pulse_s pulses;
  fmc_pkg::fmc_pulse_s seen = '0;
  int bad_count = 0;
  int n_checks = 0;
  int low_n = 0;
  int other_n;
  always #10 clk = ~clk;
  // Upper lines keep moving to show they are ignored.
  always @(posedge clk) upio <= upio + 3'h1;
  always @(posedge clk) seen <= spi_in.cs_n ? (seen | pulses) : '0;
  always @(posedge clk) low_n <= spi_in.cs_n ? low_n + int'(!standby) : 0;
  fmc_cmd #(.RECOVER_PGM_CYCLES(16'h0014), .RECOVER_OTHER_CYCLES(16'h000A)) dut (
    .clk(clk), .rst(rst), .spi_in(spi_in), .upper_io_lines(upio), .wp_n(wp_n),
    .individual_protect_select(ips), .write_permit_latch(wpl), .continuous_program_mode(cpm),
    .ready_busy_n(rbn), .program_active(pga), .erase_active(era), .so(so), .so_oe(so_oe),
    .pulses(pulses), .busy_output_enabled(busy_en), .reset_armed(armed),
    .protect_all_blocks(prot), .standby(standby));
  fmc_host u_host (.clk(clk), .spi_in(spi_in), .so(so), .so_oe(so_oe));
  function automatic logic [7:0] tbl(input logic [7:0] a);
    logic [191:0] t;
    t = {8'hFF, 24'h000060, 8'h04, 8'h01, 8'h00, fmc_pkg::TBL_VENDOR_ID_DEF, 8'hFF,
      24'h000030, 8'h09, 8'h01, 8'h00,
      8'h00, 8'hFF, 8'h01, 8'h01, 8'h00, 32'h50444653};
    return (a < 8'h18) ? t[8 * a +: 8] : 8'hFF;
  endfunction : tbl
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up
  task automatic cmd(input logic [7:0] op, input logic [3:0] n);
    logic [7:0] r;
    u_host.open_frame();
    u_host.shift(op, n, r);
    u_host.close_frame();
  endtask : cmd
  task automatic tread(input logic [7:0] a, input int n, input logic [3:0] tail);
    logic [7:0] r;
    u_host.open_frame();
    u_host.shift(fmc_pkg::OPC_TABLE_READ, 4'h8, r);
    u_host.shift(8'h00, 4'h8, r);
    u_host.shift(8'h00, 4'h8, r);
    u_host.shift(a, 4'h8, r);
    u_host.shift(8'hA5, 4'h8, r);
    for (int i = 0; i < n; i++)
    begin
      u_host.shift(8'h5A ^ i[7:0], 4'h8, r);
      chk({8'h00, r}, {8'h00, tbl(a + i[7:0])});
    end
    u_host.shift(8'hFF, tail, r);
    u_host.close_frame();
  endtask : tread
  task automatic soft_reset();
    cmd(fmc_pkg::OPC_RESET_ARM_DEF, 4'h8);
    cmd(fmc_pkg::OPC_RESET_DEF, 4'h8);
    u_host.tick(40);
  endtask : soft_reset
  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    wrap_up();
  end
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({12'h000, busy_en, armed, so_oe, standby}, 16'h0001);
    cmd(fmc_pkg::OPC_LOCK_ALL, 4'h8);
    chk(16'(seen.lock_all), 16'h0000);
    ips <= 1'b1;
    cmd(fmc_pkg::OPC_LOCK_ALL, 4'h8);
    chk(16'({seen.lock_all, seen.unlock_all}), 16'h0002);
    cmd(fmc_pkg::OPC_UNLOCK_ALL, 4'h8);
    chk(16'({seen.lock_all, seen.unlock_all}), 16'h0001);
    wpl <= 1'b0;
    cmd(fmc_pkg::OPC_LOCK_ALL, 4'h8);
    chk(16'(seen.lock_all), 16'h0000);
    wpl <= 1'b1;
    cmd(fmc_pkg::OPC_LOCK_ALL, 4'h7);
    chk(16'(seen.lock_all), 16'h0000);
    wp_n <= 1'b0;
    u_host.tick(5);
    chk(16'(prot), 16'h0001);
    ips <= 1'b0;
    u_host.tick(5);
    chk(16'(prot), 16'h0000);
    ips <= 1'b1;
    wp_n <= 1'b1;
    cpm <= 1'b1;
    cmd(fmc_pkg::OPC_BUSY_EN_DEF, 4'h8);
    for (int v = 0; v < 2; v++)
    begin
      rbn <= v[0];
      u_host.tick(2);
      chk(16'({busy_en, so_oe, so}), {13'h0000, 2'b11, v[0]});
    end
    cmd(fmc_pkg::OPC_BUSY_DIS_DEF, 4'h7);
    chk(16'(busy_en), 16'h0001);
    cmd(fmc_pkg::OPC_BUSY_DIS_DEF, 4'h8);
    chk(16'({busy_en, so_oe}), 16'h0000);
    cpm <= 1'b0;
    cmd(fmc_pkg::OPC_RESET_ARM_DEF, 4'h8);
    chk(16'(armed), 16'h0001);
    cmd(fmc_pkg::OPC_NOP_DEF, 4'h8);
    chk(16'(armed), 16'h0000);
    cmd(fmc_pkg::OPC_RESET_ARM_DEF, 4'h8);
    cmd(fmc_pkg::OPC_LOCK_ALL, 4'h8);
    cmd(fmc_pkg::OPC_RESET_DEF, 4'h8);
    chk(16'(seen.soft_reset), 16'h0000);
    soft_reset();
    chk(16'({seen.soft_reset, standby}), 16'h0003);
    other_n = low_n;
    pga <= 1'b1;
    soft_reset();
    chk(16'(seen.abort_operation), 16'h0001);
    chk(16'(low_n - other_n), 16'h000A);
    pga <= 1'b0;
    era <= 1'b1;
    soft_reset();
    chk(16'({seen.abort_operation, seen.soft_reset}), 16'h0003);
    chk(16'(low_n), 16'h000A);
    era <= 1'b0;
    tread(8'h00, 25, 4'h0);
    tread(8'h05, 2, 4'h3);
    cmd(fmc_pkg::OPC_RESET_ARM_DEF, 4'h8);
    chk(16'(armed), 16'h0001);
    wrap_up();
  end
endmodule : test_flash_misc_cmd_and_param_table
